// *** plt_pkg.sv ***
// Shared constants and types for the palette host access block
package plt_pkg;

	// ==========================================================
	// Host IO port addresses
	localparam logic [15:0] ADDR_MASK  = 16'h03c6;
	localparam logic [15:0] ADDR_RDIDX = 16'h03c7;
	localparam logic [15:0] ADDR_WRIDX = 16'h03c8;
	localparam logic [15:0] ADDR_DATA  = 16'h03c9;

	// ==========================================================
	// Reset values and codes
	localparam logic [7:0] MASK_RST     = 8'hff;
	localparam logic [7:0] INDEX_RST    = 8'h00;
	localparam logic [1:0] STATE_WRIDX  = 2'h0;
	localparam logic [1:0] STATE_RDIDX  = 2'h3;
	localparam logic [2:0] DEPTH_COMPAT = 3'h0;

	// ==========================================================
	// Byte positions within a colour sequence
	localparam logic [1:0] POS_RED   = 2'h0;
	localparam logic [1:0] POS_GREEN = 2'h1;
	localparam logic [1:0] POS_BLUE  = 2'h2;

	// ==========================================================
	// Entry layout
	localparam int IDX_W     = 8;
	localparam int LUT_W     = 24;
	localparam int LUT_DEPTH = 256;
	localparam int RED_LSB   = 16;
	localparam int GREEN_LSB = 8;
	localparam int BLUE_LSB  = 0;

	// ==========================================================
	// Answer path states and answer sources
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ANS  = 2'b10
	} plt_st_t;

	typedef enum logic [3:0] {
		SRC_MASK  = 4'b0001,
		SRC_STATE = 4'b0010,
		SRC_INDEX = 4'b0100,
		SRC_DATA  = 4'b1000
	} plt_src_t;

endpackage : plt_pkg

// *** plt_lut_ram.sv ***
// Colour table storage with one shared synchronous port
`timescale 1ns/10ps
`default_nettype none

module plt_lut_ram #(
	parameter int DEPTH = plt_pkg::LUT_DEPTH,
	parameter int AW    = plt_pkg::IDX_W,
	parameter int DW    = plt_pkg::LUT_W
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Port
	input  wire logic [AW-1:0] addr,
	input  wire logic          we,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);

	typedef struct packed {
		logic [DW-1:0] rdata;
	} plt_ram_s_t;

	plt_ram_s_t    s_q;
	plt_ram_s_t    s_d;
	logic [DW-1:0] mem [DEPTH];

	// ==========================================================
	// Read register
	always_comb begin
		s_d       = s_q;
		s_d.rdata = mem[addr];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Storage
	// no reset on contents
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	assign rdata = s_q.rdata;

endmodule : plt_lut_ram

`default_nettype wire

// *** plt_pix_path.sv ***
// Pixel masking and colour output with repaint stall handling
`timescale 1ns/10ps
`default_nettype none

module plt_pix_path (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Pixel in
	input  wire logic        pix_valid,
	input  wire logic [7:0]  pix_index,
	input  wire logic [7:0]  mask,
	input  wire logic        host_busy,
	// Table port
	output logic      [7:0]  lut_addr,
	input  wire logic [23:0] lut_rdata,
	// Colour out
	output logic      [23:0] rgb,
	output logic             rgb_valid
);

	typedef struct packed {
		logic        look;
		logic        skip;
		logic [23:0] rgb;
		logic        rgb_valid;
	} plt_pix_s_t;

	plt_pix_s_t s_q;
	plt_pix_s_t s_d;

	// ==========================================================
	// Lookup and repeat
	always_comb begin
		s_d = s_q;
		s_d.look      = pix_valid & ~host_busy;
		s_d.skip      = pix_valid & host_busy;
		s_d.rgb_valid = s_q.look | s_q.skip;
		if (s_q.look) begin
			s_d.rgb = lut_rdata;
		end
		if (s_q.skip) begin
			s_d.rgb = s_q.rgb;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign lut_addr  = pix_index & mask;
	assign rgb       = s_q.rgb;
	assign rgb_valid = s_q.rgb_valid;

endmodule : plt_pix_path

`default_nettype wire

// *** plt_host_access.sv ***
// Host IO access to the colour look-up table
//
// Operation
// - Pixel index is ANDed with the mask; mask is FFh after reset.
// - Three data reads after read index give red, green, blue of 24-bit entry.
// - Index write during a read sequence restarts it at red.
// - After third read byte, index advances, wrapping FFh to 00h.
// - Reading the read-index address returns the last-write state.
// - State bits 1-0 are 00 after write-index write, 11 after read-index.
// - Write index then red, green, blue bytes store one 24-bit entry.
// - Index write during a write sequence restarts it at red.
// - After third written byte, index advances, wrapping FFh to 00h.
// - Both index ports share one index; only write-index port reads it.
// - Data reads and data writes both use the one shared index.
// - In 6-bit mode, host bits 5-0 go to table bits 7-2, low bits cleared.
// - In 6-bit mode, reads return table bits 7-2 on 5-0, top bits zero.
// - Signature select makes data accesses reach signature data, not table.
// - Each three-byte table transfer takes one video clock; skipped pixel repeats.
// - Table contents are not touched by reset.
`timescale 1ns/10ps
`default_nettype none

module plt_host_access (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Host IO
	input  wire logic [15:0] io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	output logic             io_rdata_valid,
	// Mode controls
	input  wire logic [2:0]  depth_select_control,
	input  wire logic        signature_select_control,
	// Signature data
	input  wire logic [23:0] sig_data,
	output logic      [23:0] sig_wr_data,
	// Pixel stream
	input  wire logic        pix_valid,
	input  wire logic [7:0]  pix_index,
	output logic      [23:0] rgb,
	output logic             rgb_valid
);

	// ==========================================================
	// State and reset value
	typedef struct packed {
		plt_pkg::plt_st_t  st;
		plt_pkg::plt_src_t src;
		logic [1:0]        ans_pos;
		logic              ans_fresh;
		logic [7:0]        mask;
		logic [7:0]        index;
		logic [1:0]        pos;
		logic [1:0]        last_state;
		logic [15:0]       stage;
		logic [23:0]       hold;
		logic [7:0]        rdata;
		logic              rvalid;
		logic [23:0]       sig_wr;
	} plt_host_s_t;

	localparam plt_host_s_t RST = '{
		st:         plt_pkg::ST_IDLE,
		src:        plt_pkg::SRC_MASK,
		ans_pos:    plt_pkg::POS_RED,
		ans_fresh:  1'b0,
		mask:       plt_pkg::MASK_RST,
		index:      plt_pkg::INDEX_RST,
		pos:        plt_pkg::POS_RED,
		last_state: plt_pkg::STATE_WRIDX,
		stage:      16'h0000,
		hold:       24'h000000,
		rdata:      8'h00,
		rvalid:     1'b0,
		sig_wr:     24'h000000
	};

	plt_host_s_t s_q;
	plt_host_s_t s_d;

	// ==========================================================
	// Decode and table nets
	logic        compat;
	logic        wr_mask;
	logic        wr_rdidx;
	logic        wr_wridx;
	logic        wr_data;
	logic        rd_hit;
	logic [7:0]  wbyte;
	logic [23:0] entry;
	logic        host_busy;
	logic        lut_we;
	logic [23:0] lut_wdata;
	logic [7:0]  lut_addr;
	logic [7:0]  pix_addr;
	logic [23:0] lut_rdata;

	// ==========================================================
	// Helpers
	function automatic logic [7:0] map_wr(input logic [7:0] b, input logic c);
		return c ? {b[5:0], 2'h0} : b;
	endfunction : map_wr

	function automatic logic [7:0] map_rd(input logic [7:0] b, input logic c);
		return c ? {2'h0, b[7:2]} : b;
	endfunction : map_rd

	function automatic logic port_hit(input logic [15:0] a, input logic [15:0] p);
		return a == p;
	endfunction : port_hit

	// Host ports occupy one contiguous address block
	function automatic logic in_block(input logic [15:0] a);
		return (a >= plt_pkg::ADDR_MASK) && (a <= plt_pkg::ADDR_DATA);
	endfunction : in_block

	// Index step; eight bits make FFh roll to 00h
	function automatic logic [7:0] next_index(input logic [7:0] i);
		return i + 8'h01;
	endfunction : next_index

	function automatic logic [1:0] next_pos(input logic [1:0] p);
		return p + 2'h1;
	endfunction : next_pos

	function automatic logic [7:0] pick(input logic [23:0] e, input logic [1:0] p);
		logic [7:0] b;
		b = e[plt_pkg::BLUE_LSB +: 8];
		case (p)
			plt_pkg::POS_RED: begin
				b = e[plt_pkg::RED_LSB +: 8];
			end
			plt_pkg::POS_GREEN: begin
				b = e[plt_pkg::GREEN_LSB +: 8];
			end
			default: begin
				b = e[plt_pkg::BLUE_LSB +: 8];
			end
		endcase
		return b;
	endfunction : pick

	// ==========================================================
	// Decode
	// 6-bit compatibility when depth field is zero
	assign compat   = (depth_select_control == plt_pkg::DEPTH_COMPAT);
	assign wr_mask  = io_wr && port_hit(io_addr, plt_pkg::ADDR_MASK);
	assign wr_rdidx = io_wr && port_hit(io_addr, plt_pkg::ADDR_RDIDX);
	assign wr_wridx = io_wr && port_hit(io_addr, plt_pkg::ADDR_WRIDX);
	assign wr_data  = io_wr && port_hit(io_addr, plt_pkg::ADDR_DATA);
	assign rd_hit   = io_rd && !io_wr && in_block(io_addr);
	assign wbyte    = map_wr(io_wdata, compat);
	assign entry    = s_q.ans_fresh ? lut_rdata : s_q.hold;

	// ==========================================================
	// Host sequencing
	always_comb begin
		s_d       = s_q;
		s_d.rvalid = 1'b0;
		host_busy = 1'b0;
		lut_we    = 1'b0;
		lut_wdata = {s_q.stage, wbyte};

		// ==========================================================
		// Answer stage for the previous read
		case (s_q.st)
			plt_pkg::ST_ANS: begin
				s_d.st     = plt_pkg::ST_IDLE;
				s_d.rvalid = 1'b1;
				if (s_q.ans_fresh) begin
					s_d.hold = lut_rdata;
				end
				case (s_q.src)
					plt_pkg::SRC_MASK: begin
						s_d.rdata = s_q.mask;
					end
					plt_pkg::SRC_STATE: begin
						s_d.rdata = {6'h00, s_q.last_state};
					end
					plt_pkg::SRC_INDEX: begin
						s_d.rdata = s_q.index;
					end
					default: begin
						s_d.rdata = map_rd(pick(entry, s_q.ans_pos), compat);
					end
				endcase
			end
			default: begin
				s_d.st = plt_pkg::ST_IDLE;
			end
		endcase

		// ==========================================================
		// Writes
		if (wr_mask) begin
			s_d.mask = io_wdata;
		end
		// both index ports load one index
		if (wr_rdidx || wr_wridx) begin
			s_d.index = io_wdata;
			s_d.pos   = plt_pkg::POS_RED;
		end
		if (wr_rdidx) begin
			s_d.last_state = plt_pkg::STATE_RDIDX;
		end
		if (wr_wridx) begin
			s_d.last_state = plt_pkg::STATE_WRIDX;
		end
		if (wr_data) begin
			case (s_q.pos)
				plt_pkg::POS_RED: begin
					s_d.stage[15:8] = wbyte;
					s_d.pos         = next_pos(s_q.pos);
				end
				plt_pkg::POS_GREEN: begin
					s_d.stage[7:0] = wbyte;
					s_d.pos        = next_pos(s_q.pos);
				end
				default: begin
					if (signature_select_control) begin
						s_d.sig_wr = {s_q.stage, wbyte};
					end else begin
						// whole entry stored at write index
						lut_we    = 1'b1;
						host_busy = 1'b1;
					end
					s_d.index = next_index(s_q.index);
					s_d.pos   = plt_pkg::POS_RED;
				end
			endcase
		end

		// ==========================================================
		// Reads
		if (rd_hit) begin
			s_d.st        = plt_pkg::ST_ANS;
			s_d.ans_pos   = s_q.pos;
			s_d.ans_fresh = 1'b0;
			case (io_addr)
				plt_pkg::ADDR_MASK: begin
					s_d.src = plt_pkg::SRC_MASK;
				end
				plt_pkg::ADDR_RDIDX: begin
					s_d.src = plt_pkg::SRC_STATE;
				end
				plt_pkg::ADDR_WRIDX: begin
					s_d.src = plt_pkg::SRC_INDEX;
				end
				default: begin
					s_d.src = plt_pkg::SRC_DATA;
					if (s_q.pos == plt_pkg::POS_RED) begin
						if (signature_select_control) begin
							s_d.hold = sig_data;
						end else begin
							// entry fetched once for three bytes
							s_d.ans_fresh = 1'b1;
							host_busy     = 1'b1;
						end
					end
					// advance with wrap after third byte
					if (s_q.pos == plt_pkg::POS_BLUE) begin
						s_d.index = next_index(s_q.index);
						s_d.pos   = plt_pkg::POS_RED;
					end else begin
						s_d.pos = next_pos(s_q.pos);
					end
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Table and pixel path
	// host port addressed by shared index
	assign lut_addr = host_busy ? s_q.index : pix_addr;

	plt_lut_ram #(
		.DEPTH (plt_pkg::LUT_DEPTH),
		.AW    (plt_pkg::IDX_W),
		.DW    (plt_pkg::LUT_W)
	) u_ram (
		.clk   (clk),
		.rst_n (rst_n),
		.addr  (lut_addr),
		.we    (lut_we),
		.wdata (lut_wdata),
		.rdata (lut_rdata)
	);

	plt_pix_path u_pix (
		.clk       (clk),
		.rst_n     (rst_n),
		.pix_valid (pix_valid),
		.pix_index (pix_index),
		.mask      (s_q.mask),
		.host_busy (host_busy),
		.lut_addr  (pix_addr),
		.lut_rdata (lut_rdata),
		.rgb       (rgb),
		.rgb_valid (rgb_valid)
	);

	// ==========================================================
	// Outputs
	assign io_rdata       = s_q.rdata;
	assign io_rdata_valid = s_q.rvalid;
	assign sig_wr_data    = s_q.sig_wr;

endmodule : plt_host_access

`default_nettype wire

// *** plt_chk.sv ***
// Port checks for the palette host access block
`timescale 1ns/10ps
`default_nettype none
module plt_chk (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Host IO
	input wire logic [15:0] io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_wdata,
	input wire logic [7:0]  io_rdata,
	input wire logic        io_rdata_valid,
	// Modes and colour
	input wire logic [2:0]  depth_select_control,
	input wire logic        signature_select_control,
	input wire logic [23:0] sig_wr_data,
	input wire logic        pix_valid,
	input wire logic [23:0] rgb,
	input wire logic        rgb_valid
);
	logic       rd_req;
	logic       c_rd;
	logic       sig_wr;
	logic [1:0] st_q;
	logic [7:0] mask_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	assign rd_req = io_rd && !io_wr && io_addr >= plt_pkg::ADDR_MASK && io_addr <= plt_pkg::ADDR_DATA;
	assign c_rd = rd_req && io_addr == plt_pkg::ADDR_DATA && !signature_select_control
		&& depth_select_control == plt_pkg::DEPTH_COMPAT;
	assign sig_wr = io_wr && io_addr == plt_pkg::ADDR_DATA && signature_select_control;

	// ==========================================================
	// Shadow of mask and last index port
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q   <= plt_pkg::STATE_WRIDX;
			mask_q <= plt_pkg::MASK_RST;
		end else if (io_wr) begin
			if (io_addr == plt_pkg::ADDR_RDIDX)
				st_q <= plt_pkg::STATE_RDIDX;
			if (io_addr == plt_pkg::ADDR_WRIDX)
				st_q <= plt_pkg::STATE_WRIDX;
			if (io_addr == plt_pkg::ADDR_MASK)
				mask_q <= io_wdata;
		end
	end

	a_rd_latency: assert property (rd_req |-> ##2 io_rdata_valid)
		else $error("read answer late or missing");
	a_ans_cause: assert property (io_rdata_valid |-> $past(rd_req, 2))
		else $error("read answer without request");
	a_state_rd: assert property (rd_req && io_addr == plt_pkg::ADDR_RDIDX
		|-> ##2 io_rdata == {6'h00, $past(st_q, 2)}) else $error("state read wrong");
	a_mask_rd: assert property (rd_req && io_addr == plt_pkg::ADDR_MASK
		|-> ##2 io_rdata == $past(mask_q, 2)) else $error("mask read wrong");
	a_compat_rd: assert property (c_rd |-> ##2 io_rdata[7:6] == 2'h0)
		else $error("compat read top bits set");
	a_pix_lat: assert property (pix_valid |-> ##2 rgb_valid)
		else $error("colour strobe late or missing");
	a_rgb_hold: assert property (!rgb_valid |-> $stable(rgb))
		else $error("colour changed without strobe");
	a_sig_cause: assert property ($changed(sig_wr_data) |-> $past(sig_wr))
		else $error("signature changed without write");

	c_state: cover property (rd_req && io_addr == plt_pkg::ADDR_RDIDX);
	c_stall: cover property (pix_valid && io_wr && io_addr == plt_pkg::ADDR_DATA);
	c_sig: cover property (sig_wr);
endmodule : plt_chk
`default_nettype wire

// *** plt_host_bfm.sv ***
// Host processor model issuing byte IO cycles
`timescale 1ns/10ps
`default_nettype none
module plt_host_bfm (
	// Clock
	input  wire logic       clk,
	// Host IO
	output var logic [15:0] io_addr,
	output var logic        io_wr,
	output var logic        io_rd,
	output var logic [7:0]  io_wdata,
	input  wire logic [7:0] io_rdata,
	input  wire logic       io_rdata_valid
);
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end

	// one byte a call, then one idle cycle with address and data inverted
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		io_addr = a;
		io_wdata = v;
		io_wr = 1'b1;
		@(negedge clk);
		io_wr = 1'b0;
		io_addr = ~a;
		io_wdata = ~v;
		@(negedge clk);
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk);
		io_rd = 1'b0;
		io_addr = ~a;
		v = 8'hxx;
		repeat (3) begin
			@(negedge clk);
			if (io_rdata_valid === 1'b1)
				v = io_rdata;
		end
	endtask : rd
endmodule : plt_host_bfm
`default_nettype wire

// *** plt_host_access_tb.sv ***
// Self-checking bench for the palette host access block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module plt_host_access_tb;
	localparam logic [15:0] M = plt_pkg::ADDR_MASK;
	localparam logic [15:0] S = plt_pkg::ADDR_RDIDX;
	localparam logic [15:0] W = plt_pkg::ADDR_WRIDX;
	localparam logic [15:0] D = plt_pkg::ADDR_DATA;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] io_addr;
	logic        io_wr, io_rd, io_rdata_valid, rgb_valid;
	logic [7:0]  io_wdata, io_rdata, d;
	logic [7:0]  pix_index = 8'h00;
	logic        pix_valid = 1'b0;
	logic [2:0]  depth_select_control = 3'h1;
	logic        signature_select_control = 1'b0;
	logic [23:0] sig_data = 24'ha1b2c3;
	logic [23:0] sig_wr_data, rgb;
	int          n_fail = 0;
	int          checks_done = 0;
	int          cyc = 0;

	always #25 clk = ~clk;

	plt_host_access u_dut (.clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rdata_valid,
		.depth_select_control, .signature_select_control, .sig_data, .sig_wr_data, .pix_valid, .pix_index,
		.rgb, .rgb_valid);
	plt_host_bfm u_host (.clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rdata_valid);

	task automatic finish_test;
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		u_host.rd(a, d);
		`CHK(d, e)
	endtask : rchk

	task automatic wr3(input bit ix, input logic [7:0] i, input logic [23:0] c);
		if (ix)
			u_host.wr(W, i);
		for (int k = 2; k >= 0; k--)
			u_host.wr(D, c[8*k+:8]);
	endtask : wr3

	task automatic rd3(input bit ix, input logic [7:0] i, input logic [23:0] c);
		if (ix)
			u_host.wr(S, i);
		for (int k = 2; k >= 0; k--)
			rchk(D, c[8*k+:8]);
	endtask : rd3

	task automatic pchk(input logic [7:0] p, input logic [23:0] e);
		pix_index = p;
		pix_valid = 1'b1;
		@(negedge clk);
		pix_valid = 1'b0;
		@(negedge clk);
		`CHK({rgb_valid, rgb}, {1'b1, e})
	endtask : pchk

	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			finish_test;
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		rchk(M, 8'hff);
		rchk(S, 8'h00);
		wr3(1, 8'hff, 24'h112233);
		rchk(W, 8'h00);
		rchk(S, 8'h00);
		wr3(0, 8'h00, 24'h445566);
		rd3(1, 8'hff, 24'h112233);
		rchk(S, 8'h03);
		rd3(0, 8'h00, 24'h445566);
		rchk(W, 8'h01);
		// Partial sequences abandoned by index writes
		u_host.wr(W, 8'h05);
		u_host.wr(D, 8'h0a);
		u_host.wr(D, 8'h0b);
		wr3(1, 8'h05, 24'h0c0d0e);
		u_host.wr(S, 8'h05);
		rchk(D, 8'h0c);
		rd3(1, 8'h05, 24'h0c0d0e);
		rchk(W, 8'h06);
		u_host.wr(M, 8'h0f);
		rchk(M, 8'h0f);
		pchk(8'hf5, 24'h0c0d0e);
		pchk(8'h10, 24'h445566);
		u_host.wr(W, 8'h01);
		u_host.wr(D, 8'h01);
		u_host.wr(D, 8'h02);
		fork
			u_host.wr(D, 8'h03);
			pchk(8'h05, 24'h445566);
		join
		pchk(8'h01, 24'h010203);
		u_host.wr(M, 8'hff);
		depth_select_control = plt_pkg::DEPTH_COMPAT;
		wr3(1, 8'h07, 24'hff813f);
		rd3(1, 8'h07, 24'h3f013f);
		pchk(8'h07, 24'hfc04fc);
		depth_select_control = 3'h1;
		signature_select_control = 1'b1;
		rd3(1, 8'h20, 24'ha1b2c3);
		wr3(1, 8'h20, 24'h090807);
		`CHK(sig_wr_data, 24'h090807)
		signature_select_control = 1'b0;
		// Mid-run reset keeps table contents
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		`CHK(sig_wr_data, 24'h000000)
		rchk(M, 8'hff);
		rchk(S, 8'h00);
		rchk(W, 8'h00);
		pchk(8'h07, 24'hfc04fc);
		finish_test;
	end
endmodule : plt_host_access_tb

bind plt_host_access plt_chk u_chk (.clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
	.io_rdata_valid, .depth_select_control, .signature_select_control, .sig_wr_data, .pix_valid, .rgb,
	.rgb_valid);
`default_nettype wire
